// *** common/seebfe_map.vh ***
// Constants for the two-wire memory bus front end
`ifndef SEEBFE_MAP_VH
`define SEEBFE_MAP_VH
`define SEEBFE_REG_CTRL       32'h0000_0000
`define SEEBFE_REG_STATUS     32'h0000_0004
`define SEEBFE_REG_LASTADDR   32'h0000_0008
`define SEEBFE_REG_WRDONE     32'h0000_000c
`define SEEBFE_CTRL_ENABLE    0
`define SEEBFE_CTRL_RESET_VAL 32'h0000_0001
`define SEEBFE_STAT_BUSY      0
`define SEEBFE_STAT_STANDBY   1
`define SEEBFE_STAT_SELECTED  2
`define SEEBFE_STAT_READ      3
`define SEEBFE_STAT_WP        4
`define SEEBFE_WORD_BITS      8
`define SEEBFE_PROG_TIME_MS   5
`define SEEBFE_CLK_MHZ        100
`define SEEBFE_PROG_CYCLES    (`SEEBFE_PROG_TIME_MS * 1000 * `SEEBFE_CLK_MHZ)
`define SEEBFE_RESP_OKAY      2'b00
`define SEEBFE_RESP_SLVERR    2'b10
`endif

// *** src/seebfe_sync2.v ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module seebfe_sync2 #(
  parameter W = 1
) (
  input  wire         i_clk,
  input  wire         i_nrst,
  input  wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // First stage only feeds second stage; reset to released bus level
  always @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      meta_q <= {W{1'b1}};
      sync_q <= {W{1'b1}};
    end
    else
    begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;
endmodule // seebfe_sync2

// *** src/seebfe_top.v ***
// Two-wire serial memory bus front end with AXI4-Lite status port
// Behaviour
// - Data line changes only while clock low; changes with clock high are start/stop.
// - Falling data with clock high is start; device begins a new address word.
// - Rising data with clock high is stop; after a read, enter standby.
// - Words are eight bits; the receiver pulls data low on the ninth clock.
// - Standby at power-up and after stop once internal work has finished.
// - Address word bits 7..4 must equal the device-type identifier.
// - Address word bits 3..1 must match the three select straps.
// - Address bit 0 high selects read, low selects write.
// - Matching address is acknowledged; mismatch gets no acknowledge and standby.
// - Write-protect high inhibits all array writes; low allows normal access.
// - Self-timed write cycle from stop lasts no longer than 5 ms.
// - During the internal write cycle all bus inputs are ignored.
// - Address polls are acknowledged only after the write cycle completes.
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "seebfe_map.vh"
module seebfe_top #(
  parameter [3:0]  DEV_TYPE    = 4'h5,   // Arbitrary device-type code
  parameter [31:0] PROG_CYCLES = `SEEBFE_PROG_CYCLES
) (
  input  wire        i_clk,
  input  wire        i_nrst,
  input  wire        i_scl,
  input  wire        i_sda,
  output wire        o_sda,
  output wire        o_sda_oe,
  input  wire        i_chip_select_strap_2,
  input  wire        i_chip_select_strap_1,
  input  wire        i_chip_select_strap_0,
  input  wire        i_wp,
  output wire        o_wr_byte_valid,
  output wire [7:0]  o_wr_byte,
  input  wire [31:0] i_s_axi_awaddr,
  input  wire        i_s_axi_awvalid,
  output wire        o_s_axi_awready,
  input  wire [31:0] i_s_axi_wdata,
  input  wire [3:0]  i_s_axi_wstrb,
  input  wire        i_s_axi_wvalid,
  output wire        o_s_axi_wready,
  output wire [1:0]  o_s_axi_bresp,
  output wire        o_s_axi_bvalid,
  input  wire        i_s_axi_bready,
  input  wire [31:0] i_s_axi_araddr,
  input  wire        i_s_axi_arvalid,
  output wire        o_s_axi_arready,
  output wire [31:0] o_s_axi_rdata,
  output wire [1:0]  o_s_axi_rresp,
  output wire        o_s_axi_rvalid,
  input  wire        i_s_axi_rready
);
  localparam [2:0] ST_IDLE = 3'd0;   // Standby
  localparam [2:0] ST_ADDR = 3'd1;   // Shifting address word
  localparam [2:0] ST_AACK = 3'd2;   // Address acknowledge slot
  localparam [2:0] ST_WDAT = 3'd3;   // Receiving write bytes
  localparam [2:0] ST_DACK = 3'd4;   // Data acknowledge slot
  localparam [2:0] ST_READ = 3'd5;   // Read flow handled elsewhere; wait for stop
  localparam [2:0] ST_PROG = 3'd6;   // Internal write cycle

  wire [5:0] pins_s;
  wire       scl_s;
  wire       sda_s;
  wire       wp_s;
  wire [2:0] strap_s;

  // Every pin passes two flops before use
  seebfe_sync2 #(
    .W (6)
  ) u_sync (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_d    ({i_scl, i_sda, i_wp, i_chip_select_strap_2, i_chip_select_strap_1, i_chip_select_strap_0}),
    .o_q    (pins_s)
  );

  assign scl_s   = pins_s[5];
  assign sda_s   = pins_s[4];
  assign wp_s    = pins_s[3];
  assign strap_s = pins_s[2:0];

  reg        scl_q;
  reg        sda_q;
  reg [2:0]  state_q;
  reg [3:0]  bit_cnt_q;
  reg [7:0]  shift_q;
  reg        ack_q;
  reg        rd_q;
  reg        wr_seen_q;
  reg [31:0] prog_cnt_q;
  reg        wr_valid_q;
  reg [7:0]  wr_byte_q;
  reg        enable_q;
  reg [7:0]  last_addr_q;
  reg [15:0] wr_done_q;

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_ev = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_ev  = scl_s & scl_q & ~sda_q & sda_s;
  wire addr_hit = (shift_q[7:4] == DEV_TYPE) && (shift_q[3:1] == strap_s);
  wire prog_end = (prog_cnt_q == PROG_CYCLES - 32'd1);

  // Bus protocol engine; start and stop override any bit in flight
  always @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      scl_q       <= 1'b1;  // Released level, so no false edge after reset
      sda_q       <= 1'b1;
      state_q     <= ST_IDLE;
      bit_cnt_q   <= 4'h0;
      shift_q     <= 8'h00;
      ack_q       <= 1'b0;
      rd_q        <= 1'b0;
      wr_seen_q   <= 1'b0;
      prog_cnt_q  <= 32'h0000_0000;
      wr_valid_q  <= 1'b0;
      wr_byte_q   <= 8'h00;
      last_addr_q <= 8'h00;
      wr_done_q   <= 16'h0000;
    end
    else
    begin
      // Edge history keeps running even while programming
      scl_q      <= scl_s;
      sda_q      <= sda_s;
      wr_valid_q <= 1'b0;
      if (state_q == ST_PROG)
      begin
        // Bus is ignored while programming, so polls get no acknowledge
        ack_q <= 1'b0;
        if (prog_end)
        begin
          state_q    <= ST_IDLE;
          prog_cnt_q <= 32'h0000_0000;
          wr_done_q  <= wr_done_q + 16'h0001;
        end
        else
          prog_cnt_q <= prog_cnt_q + 32'h0000_0001;
      end
      else if (!enable_q)
      begin
        state_q <= ST_IDLE;
        ack_q   <= 1'b0;
      end
      else if (start_ev)
      begin
        state_q   <= ST_ADDR;
        bit_cnt_q <= 4'h0;
        ack_q     <= 1'b0;
      end
      else if (stop_ev)
      begin
        ack_q <= 1'b0;
        // Only a write that really delivered data and was not protected starts programming
        if (wr_seen_q && !rd_q)
          state_q <= ST_PROG;
        else
          state_q <= ST_IDLE;
        wr_seen_q <= 1'b0;
      end
      else
      begin
        case (state_q)
          ST_ADDR, ST_WDAT:
          begin
            if (scl_rise)
            begin
              shift_q   <= {shift_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            else if (scl_fall && bit_cnt_q == `SEEBFE_WORD_BITS)
            begin
              bit_cnt_q <= 4'h0;
              if (state_q == ST_ADDR)
              begin
                last_addr_q <= shift_q;
                if (addr_hit)
                begin
                  ack_q   <= 1'b1;
                  rd_q    <= shift_q[0];
                  state_q <= ST_AACK;
                end
                else
                  state_q <= ST_IDLE;
              end
              else
              begin
                ack_q      <= 1'b1;
                wr_byte_q  <= shift_q;
                wr_valid_q <= ~wp_s;
                if (!wp_s)
                  wr_seen_q <= 1'b1;
                state_q    <= ST_DACK;
              end
            end
          end
          ST_AACK, ST_DACK:
          begin
            // Release after the ninth clock falls
            if (scl_fall)
            begin
              ack_q   <= 1'b0;
              state_q <= (state_q == ST_AACK && rd_q) ? ST_READ : ST_WDAT;
            end
          end
          ST_READ:
            state_q <= ST_READ;
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Open-drain data line: low or released only
  assign o_sda    = 1'b0;
  assign o_sda_oe = ack_q;

  assign o_wr_byte_valid = wr_valid_q;
  assign o_wr_byte       = wr_byte_q;

  // AXI4-Lite slave: write address and data taken in either order
  reg        aw_got_q;
  reg        w_got_q;
  reg [31:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  reg        bvalid_q;
  reg [1:0]  bresp_q;
  reg        rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0]  rresp_q;

  assign o_s_axi_awready = ~aw_got_q & ~bvalid_q;
  assign o_s_axi_wready  = ~w_got_q & ~bvalid_q;
  assign o_s_axi_bvalid  = bvalid_q;
  assign o_s_axi_bresp   = bresp_q;
  assign o_s_axi_arready = ~rvalid_q;
  assign o_s_axi_rvalid  = rvalid_q;
  assign o_s_axi_rdata   = rdata_q;
  assign o_s_axi_rresp   = rresp_q;

  wire        aw_now   = aw_got_q | (i_s_axi_awvalid & o_s_axi_awready);
  wire        w_now    = w_got_q | (i_s_axi_wvalid & o_s_axi_wready);
  wire [31:0] aw_eff   = aw_got_q ? aw_addr_q : i_s_axi_awaddr;
  wire [31:0] wd_eff   = w_got_q ? w_data_q : i_s_axi_wdata;
  wire [3:0]  ws_eff   = w_got_q ? w_strb_q : i_s_axi_wstrb;

  // Write channel; only the control word is writable
  always @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      aw_addr_q <= 32'h0000_0000;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `SEEBFE_RESP_OKAY;
      enable_q  <= |(`SEEBFE_CTRL_RESET_VAL & (32'h0000_0001 << `SEEBFE_CTRL_ENABLE));
    end
    else
    begin
      if (bvalid_q && i_s_axi_bready)
        bvalid_q <= 1'b0;
      if (aw_now && w_now && !bvalid_q)
      begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        if (aw_eff[7:0] == `SEEBFE_REG_CTRL)
        begin
          bresp_q <= `SEEBFE_RESP_OKAY;
          if (ws_eff[0])
            enable_q <= wd_eff[`SEEBFE_CTRL_ENABLE];
        end
        else if (aw_eff[7:0] == `SEEBFE_REG_STATUS || aw_eff[7:0] == `SEEBFE_REG_LASTADDR ||
                 aw_eff[7:0] == `SEEBFE_REG_WRDONE)
          bresp_q <= `SEEBFE_RESP_OKAY;  // Read-only; write dropped
        else
          bresp_q <= `SEEBFE_RESP_SLVERR;
      end
      else
      begin
        if (i_s_axi_awvalid && o_s_axi_awready)
        begin
          aw_got_q  <= 1'b1;
          aw_addr_q <= i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid && o_s_axi_wready)
        begin
          w_got_q  <= 1'b1;
          w_data_q <= i_s_axi_wdata;
          w_strb_q <= i_s_axi_wstrb;
        end
      end
    end
  end

  // Read channel; answer one cycle after the address is taken
  always @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `SEEBFE_RESP_OKAY;
    end
    else if (rvalid_q)
    begin
      if (i_s_axi_rready)
        rvalid_q <= 1'b0;
    end
    else if (i_s_axi_arvalid)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= `SEEBFE_RESP_OKAY;
      case (i_s_axi_araddr[7:0])
        `SEEBFE_REG_CTRL:     rdata_q <= {31'h0000_0000, enable_q};
        `SEEBFE_REG_STATUS:   rdata_q <= {27'h000_0000, wp_s, rd_q, (state_q != ST_IDLE),
                                          (state_q == ST_IDLE), (state_q == ST_PROG)};
        `SEEBFE_REG_LASTADDR: rdata_q <= {24'h00_0000, last_addr_q};
        `SEEBFE_REG_WRDONE:   rdata_q <= {16'h0000, wr_done_q};
        default:
        begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `SEEBFE_RESP_SLVERR;
        end
      endcase
    end
  end
endmodule // seebfe_top

// *** sim/seebfe_checker.sv ***
// Port checker for the two-wire memory bus front end
`timescale 1ns/1ns
module seebfe_checker (
  input wire i_clk,
  input wire i_nrst,
  input wire i_wp,
  input wire o_sda,
  input wire o_sda_oe,
  input wire o_wr_byte_valid,
  input wire i_s_axi_awvalid,
  input wire o_s_axi_awready,
  input wire i_s_axi_wvalid,
  input wire o_s_axi_wready,
  input wire o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire i_s_axi_arvalid,
  input wire o_s_axi_arready,
  input wire o_s_axi_rvalid,
  input wire i_s_axi_rready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Protect pin held long enough to have crossed the synchroniser
  sequence s_wp_held;
    i_wp [*5];
  endsequence
  sequence s_wr_taken;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  property p_drive_low;
    o_sda == 1'b0;
  endproperty
  property p_ack_stands;
    $rose(o_sda_oe) |-> o_sda_oe [*6];
  endproperty
  property p_byte_acked;
    $rose(o_wr_byte_valid) |-> ##[0:2] o_sda_oe;
  endproperty
  property p_wp_blocks;
    s_wp_held |-> !o_wr_byte_valid;
  endproperty
  property p_bresp_next;
    s_wr_taken |=> o_s_axi_bvalid;
  endproperty
  property p_bvalid_holds;
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid;
  endproperty
  property p_rvalid_next;
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid;
  endproperty
  property p_rvalid_holds;
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid;
  endproperty
  property p_aw_blocked;
    o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready;
  endproperty
  property p_ack_release;
    $rose(o_sda_oe) |-> ##[1:1000] !o_sda_oe;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("data line driven high");
  a_ack_stands: assert property (p_ack_stands) else $error("acknowledge too short");
  a_byte_acked: assert property (p_byte_acked) else $error("byte taken without ack");
  a_wp_blocks: assert property (p_wp_blocks) else $error("byte taken while protected");
  a_bresp_next: assert property (p_bresp_next) else $error("write response late");
  a_bvalid_holds: assert property (p_bvalid_holds) else $error("write response dropped");
  a_rvalid_next: assert property (p_rvalid_next) else $error("read response late");
  a_rvalid_holds: assert property (p_rvalid_holds) else $error("read response dropped");
  a_aw_blocked: assert property (p_aw_blocked) else $error("write taken while busy");
  a_ack_release: assert property (p_ack_release) else $error("data line never released");
endmodule // seebfe_checker
bind seebfe_top seebfe_checker chk_u (.*);

// *** sim/seebfe_ctl_model.sv ***
// Behavioural two-wire bus controller: clock and open-drain data
`timescale 1ns/1ns
module seebfe_ctl_model (
  input  wire  i_clk,
  input  wire  i_line,
  output logic o_scl = 1'b1,
  output logic o_oe  = 1'b0
);
  task tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // One 8-cycle bus clock; data moves only mid-low so it never looks like framing
  task bit_io(input logic b, output logic r);
    tick(2);
    o_oe <= !b;
    tick(2);
    o_scl <= 1'b1;
    tick(2);
    r = i_line;
    tick(2);
    o_scl <= 1'b0;
  endtask
  // Falling data under high clock
  task start();
    tick(2);
    o_oe <= 1'b0;
    tick(2);
    o_scl <= 1'b1;
    tick(3);
    o_oe <= 1'b1;
    tick(3);
    o_scl <= 1'b0;
  endtask
  // Rising data under high clock; clock then stands high
  task stop();
    tick(2);
    o_oe <= 1'b1;
    tick(2);
    o_scl <= 1'b1;
    tick(3);
    o_oe <= 1'b0;
    tick(3);
  endtask
  // Eight bits MSB first, then the ninth clock with the line released
  task send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Protocol recovery after an interrupted word
  task recover();
    logic r;
    start();
    repeat (9) bit_io(1'b1, r);
    start();
    stop();
  endtask
endmodule // seebfe_ctl_model

// *** sim/tb_top.sv ***
// Self-checking bench for the two-wire memory bus front end
`timescale 1ns/1ns
module tb_top;
  localparam int PROG = 400;
  localparam logic [3:0] DEV = 4'h5; // Arbitrary device-type code
  logic i_clk = 1'b0, i_nrst = 1'b0, i_wp = 1'b0;
  logic [2:0] st = 3'h0, s;
  logic [31:0] i_s_axi_awaddr = 32'h0, i_s_axi_wdata = 32'h0, i_s_axi_araddr = 32'h0, v;
  logic [3:0] i_s_axi_wstrb = 4'hf;
  logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
  logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0, ack;
  logic [7:0] a, d;
  logic [1:0] rs;
  wire i_scl, i_sda, o_sda, o_sda_oe, o_wr_byte_valid, o_s_axi_awready, o_s_axi_wready;
  wire o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, ctl_oe;
  wire [7:0] o_wr_byte;
  wire [1:0] o_s_axi_bresp, o_s_axi_rresp;
  wire [31:0] o_s_axi_rdata;
  wire i_chip_select_strap_2 = st[2];
  wire i_chip_select_strap_1 = st[1];
  wire i_chip_select_strap_0 = st[0];
  int mismatches = 0, samples_checked = 0, cyc = 0, nwr = 0, t;
  // Pulled-up line, low while either party pulls it
  assign i_sda = !(ctl_oe || (o_sda_oe && !o_sda));
  seebfe_top #(.DEV_TYPE(DEV), .PROG_CYCLES(PROG)) dut_u (.*);
  seebfe_ctl_model ctl_u (.i_clk(i_clk), .i_line(i_sda), .o_scl(i_scl), .o_oe(ctl_oe));
  initial forever #5 i_clk = ~i_clk;
  // Cycle count for the hang guard, and accepted write bytes
  always @(posedge i_clk)
  begin
    cyc++;
    if (o_wr_byte_valid === 1'b1)
      nwr++;
    if (cyc == 20000)
    begin
      mismatches++;
      results();
    end
  end
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask
  task results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Each channel released at its own handshake; one idle edge keeps strobes apart
  task axw(input logic [31:0] ad, input logic [31:0] dt);
    i_s_axi_awaddr <= ad;
    i_s_axi_wdata <= dt;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (o_s_axi_awready)
        i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready)
        i_s_axi_wvalid <= 1'b0;
    end while (o_s_axi_bvalid !== 1'b1);
    rs = o_s_axi_bresp;
    i_s_axi_bready <= 1'b0;
    @(posedge i_clk);
  endtask
  task axr(input logic [31:0] ad, output logic [31:0] dt);
    i_s_axi_araddr <= ad;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (o_s_axi_arready)
        i_s_axi_arvalid <= 1'b0;
    end while (o_s_axi_rvalid !== 1'b1);
    dt = o_s_axi_rdata;
    rs = o_s_axi_rresp;
    i_s_axi_rready <= 1'b0;
    @(posedge i_clk);
  endtask
  function automatic logic hit(input logic [7:0] ad, input logic [2:0] sp);
    return ad[7:4] == DEV && ad[3:1] == sp;
  endfunction
  // Address poll: start, address word, stop
  task poll(output logic k);
    ctl_u.start();
    ctl_u.send({DEV, s, 1'b0}, k);
    ctl_u.stop();
  endtask
  initial
  begin
    void'($urandom(37377));
    repeat (16) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (8) @(posedge i_clk);
    axr(32'h0, v);
    chk("ctrl reset", v, 32'h1);
    axr(32'h4, v);
    chk("standby at reset", v[1], 1'b1);
    axr(32'h20, v);
    chk("unmapped resp", rs, 2'b10);
    axw(32'h20, 32'h0);
    chk("unmapped write resp", rs, 2'b10);
    axw(32'h4, 32'h0);
    chk("read-only write resp", rs, 2'b00);
    axr(32'h0, v);
    chk("ctrl after ro write", v, 32'h1);
    // Random address words; first four with zero straps
    for (int i = 0; i < 16; i++)
    begin
      s = (i < 4) ? 3'h0 : 3'($urandom);
      st <= s;
      a = 8'($urandom);
      if (i[0])
        a[7:4] = DEV;
      if (i[1])
        a[3:1] = s;
      if (i == 3 || i == 7)
        a[0] = i[2];
      ctl_u.start();
      ctl_u.send(a, ack);
      chk("addr ack", ack, hit(a, s));
      axr(32'h4, v);
      chk("select state", v[2:1], hit(a, s) ? 2'b10 : 2'b01);
      if (hit(a, s))
        chk("direction", v[3], a[0]);
      axr(32'h8, v);
      chk("last address", v, {24'h00_0000, a});
      ctl_u.stop();
      axr(32'h4, v);
      chk("standby after stop", v[1], 1'b1);
    end
    // Byte write, then polling through the program cycle
    s = 3'($urandom);
    st <= s;
    d = 8'($urandom);
    ctl_u.start();
    ctl_u.send({DEV, s, 1'b0}, ack);
    ctl_u.send(d, ack);
    chk("data ack", ack, 1'b1);
    chk("byte", o_wr_byte, d);
    chk("byte count", nwr, 1);
    ctl_u.stop();
    t = cyc;
    poll(ack);
    chk("busy poll", ack, 1'b0);
    axr(32'h4, v);
    chk("busy", v[0], 1'b1);
    for (int j = 0; j < 10 && ack !== 1'b1; j++)
      poll(ack);
    chk("poll ack", ack, 1'b1);
    chk("program time", cyc - t <= PROG + 200, 1'b1);
    axr(32'h0c, v);
    chk("write cycles", v, 32'h1);
    // Protected write: acked, nothing programmed, no busy time
    i_wp <= 1'b1;
    ctl_u.start();
    ctl_u.send({DEV, s, 1'b0}, ack);
    ctl_u.send(8'($urandom), ack);
    chk("byte count wp", nwr, 1);
    ctl_u.stop();
    poll(ack);
    chk("poll wp", ack, 1'b1);
    axr(32'h4, v);
    chk("wp status", v[4], 1'b1);
    axr(32'h0c, v);
    chk("write cycles wp", v, 32'h1);
    i_wp <= 1'b0;
    // Interrupted word, recovery, then a fresh address
    ctl_u.start();
    repeat (3) ctl_u.bit_io(1'b0, ack);
    ctl_u.recover();
    poll(ack);
    chk("after recovery", ack, 1'b1);
    // Cleared low strobe leaves the enable bit alone
    i_s_axi_wstrb <= 4'h0;
    axw(32'h0, 32'h0);
    axr(32'h0, v);
    chk("strobe off", v, 32'h1);
    i_s_axi_wstrb <= 4'hf;
    // Disabled front end stays silent
    axw(32'h0, 32'h0);
    poll(ack);
    chk("disabled", ack, 1'b0);
    axw(32'h0, 32'h1);
    chk("write resp", rs, 2'b00);
    poll(ack);
    chk("re-enabled", ack, 1'b1);
    results();
  end
endmodule // tb_top
